// *** hdl/ssp_pkg.sv ***
// Function
// - Master drives shift clock from its own divider; slave takes external shift clock.
// - Internal serial clock comes from a divider with a 16-bit reload value.
// - Transmit holding word moves into the shift register once that register is empty.
// - Master starts right after loading; slave waits for incoming shift clock edges.
// - Every transfer transmits and receives the same number of bits at once.
// - Transfer start sets busy and pulses the transmit request.
// - After 2 to 16 bits, shift register goes to receive holding; receive pulse.
// - Busy clears with the receive copy when no further word is waiting.
// - Word length programmable from 2 to 16 bits.
// - Direction bit: 0 sends least significant bit first, 1 most significant first.
// - Holding register words are right aligned with the word's LSB at bit 0.
// - Transmit bits above width are ignored; receive bits above width are undefined.
// - One clock edge shifts data out, the opposite edge samples input.
// - Phase bit picks leading or trailing edge for shifting out.
// - Polarity bit sets clock idle level; idle high makes leading edge falling.
// - With serial enable 0 the control address shows configuration bits.
// - With serial enable 1 the control address shows status flags.
// - Function code 011 puts serial signals on port pins 0 to 6.
// - Master puts first bit out one divider tick after loading, only while enabled.
// - Slave drives first bit immediately on loading.
// - Chip selects assert half a bit before data and release half a bit after.
// - Data-out keeps the last transmitted bit until the next transfer.
package ssp_pkg;
  // ===========================================================================
  // Register map (byte addresses on the Avalon bus)
  localparam logic [5:0] SSP_OFS_CTRL = 6'h00;
  localparam logic [5:0] SSP_OFS_BAUD = 6'h04;
  localparam logic [5:0] SSP_OFS_TXH = 6'h08;
  localparam logic [5:0] SSP_OFS_RXH = 6'h0c;
  localparam logic [5:0] SSP_OFS_MODE = 6'h10;
  localparam logic [5:0] SSP_OFS_PDIR = 6'h14;
  localparam logic [5:0] SSP_OFS_PDATA = 6'h18;
  localparam logic [5:0] SSP_OFS_PIN = 6'h1c;
  localparam logic [5:0] SSP_OFS_CSEN = 6'h20;
  // ===========================================================================
  // Control register fields
  localparam int SSP_B_MSB = 4;
  localparam int SSP_B_PH = 5;
  localparam int SSP_B_PO = 6;
  localparam int SSP_B_BUSY = 8;
  localparam int SSP_B_TXF = 9;
  localparam int SSP_B_RXF = 10;
  localparam int SSP_B_MS = 14;
  localparam int SSP_B_EN = 15;
  // ===========================================================================
  // Reset values and codes
  localparam logic [15:0] SSP_CTRL_RST = 16'h0007;
  localparam logic [15:0] SSP_BAUD_RST = 16'h0000;
  localparam logic [3:0] SSP_CSEN_RST = 4'hf;
  localparam logic [2:0] SSP_MODE_SERIAL = 3'h3;
  // Pin slots of the serial function on the low port half.
  localparam int SSP_P_MO = 0;
  localparam int SSP_P_MI = 1;
  localparam int SSP_P_CLK = 2;
  localparam int SSP_P_CS = 3;
  typedef enum logic [3:0] {
    SSP_IDLE = 4'b0001,
    SSP_LEAD = 4'b0010,
    SSP_SHIFT = 4'b0100,
    SSP_TRAIL = 4'b1000
  } ssp_state_t;
endpackage : ssp_pkg

// *** hdl/ssp_top.sv ***
`timescale 1ns/10ps
module ssp_top (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [15:0] gpp_in,
  output logic [15:0] gpp_out,
  output logic [15:0] gpp_oe,
  output logic tx_request_irq,
  output logic rx_complete_irq
);
  import ssp_pkg::*;

  // ===========================================================================
  // Software state
  logic [15:0] serial_control_reg_r;
  logic [15:0] baud_reload_reg_r;
  logic [15:0] tx_holding_reg_r;
  logic [15:0] rx_holding_reg_r;
  logic [2:0] peripheral_function_field_r;
  logic [15:0] port_direction_reg_r;
  logic [15:0] port_data_r;
  logic [3:0] cs_enable_n_r;
  logic tx_full_r;
  logic rx_full_r;
  logic transfer_busy_flag_r;
  logic ack_r;

  // ===========================================================================
  // Engine state
  ssp_state_t state_r;
  logic [15:0] baud_cnt_r;
  logic [15:0] shreg_r;
  logic [4:0] edge_cnt_r;
  logic sample_r;
  logic out_bit_r;
  logic sclk_r;
  logic cs_active_r;
  logic [15:0] pin_s1_r;
  logic [15:0] pin_s2_r;
  logic clk_prev_r;

  logic serial_enable_bit;
  logic role_master_select;
  logic msb_first_select;
  logic clock_phase_select;
  logic clock_idle_level;
  logic [4:0] nbits;
  logic [4:0] last_edge;
  logic tick;
  logic clk_edge;
  logic edge_ev;
  logic is_sample;
  logic in_bit;
  logic final_edge;
  logic start_load;
  logic bus_acc;
  logic wr_en;
  logic rd_en;
  logic [15:0] wmask;
  logic [15:0] ctrl_view;
  logic [15:0] shifted;
  logic [15:0] rx_word;

  assign serial_enable_bit = serial_control_reg_r[SSP_B_EN];
  assign role_master_select = serial_control_reg_r[SSP_B_MS];
  assign msb_first_select = serial_control_reg_r[SSP_B_MSB];
  assign clock_phase_select = serial_control_reg_r[SSP_B_PH];
  assign clock_idle_level = serial_control_reg_r[SSP_B_PO];
  // A width code of 0 would mean a 1-bit word; it is treated as 2 bits.
  assign nbits = (serial_control_reg_r[3:0] == 4'h0) ? 5'h02 : {1'b0, serial_control_reg_r[3:0]} + 5'h01;
  assign last_edge = 5'((nbits << 1) - 5'h01);

  // ===========================================================================
  // Avalon slave: one wait cycle on every access
  assign bus_acc = read | write;
  assign waitrequest = bus_acc & ~ack_r;
  assign wr_en = write & ack_r;
  assign rd_en = read & ack_r;
  assign wmask = {{8{byteenable[1]}}, {8{byteenable[0]}}};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_acc & ~ack_r;
    end
  end

  always_comb begin
    if (serial_enable_bit) begin
      ctrl_view = 16'h0000;
      ctrl_view[SSP_B_EN] = 1'b1;
      ctrl_view[SSP_B_MS] = role_master_select;
      ctrl_view[SSP_B_BUSY] = transfer_busy_flag_r;
      ctrl_view[SSP_B_TXF] = tx_full_r;
      ctrl_view[SSP_B_RXF] = rx_full_r;
    end else begin
      ctrl_view = serial_control_reg_r;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= 32'h0000_0000;
    end else if (bus_acc & ~ack_r & read) begin
      if (address == SSP_OFS_CTRL) begin
        readdata <= {16'h0000, ctrl_view};
      end else if (address == SSP_OFS_BAUD) begin
        readdata <= {16'h0000, baud_reload_reg_r};
      end else if (address == SSP_OFS_TXH) begin
        readdata <= {16'h0000, tx_holding_reg_r};
      end else if (address == SSP_OFS_RXH) begin
        readdata <= {16'h0000, rx_holding_reg_r};
      end else if (address == SSP_OFS_MODE) begin
        readdata <= {29'h0000_0000, peripheral_function_field_r};
      end else if (address == SSP_OFS_PDIR) begin
        readdata <= {16'h0000, port_direction_reg_r};
      end else if (address == SSP_OFS_PDATA) begin
        readdata <= {16'h0000, port_data_r};
      end else if (address == SSP_OFS_PIN) begin
        readdata <= {16'h0000, pin_s2_r};
      end else if (address == SSP_OFS_CSEN) begin
        readdata <= {28'h000_0000, cs_enable_n_r};
      end else begin
        readdata <= 32'h0000_0000;
      end
    end
  end

  // Configuration bits are frozen while enabled; only the enable bit stays writable.
  // The status bits have no storage, so software cannot disturb busy.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      serial_control_reg_r <= SSP_CTRL_RST;
      baud_reload_reg_r <= SSP_BAUD_RST;
      peripheral_function_field_r <= 3'h0;
      port_direction_reg_r <= 16'h0000;
      port_data_r <= 16'h0000;
      cs_enable_n_r <= SSP_CSEN_RST;
    end else if (wr_en) begin
      if (address == SSP_OFS_CTRL) begin
        if (serial_enable_bit) begin
          if (byteenable[1]) begin
            serial_control_reg_r[SSP_B_EN] <= writedata[SSP_B_EN];
          end
        end else begin
          serial_control_reg_r <= (serial_control_reg_r & ~wmask) | (writedata[15:0] & wmask & 16'hc07f);
        end
      end else if (address == SSP_OFS_BAUD) begin
        baud_reload_reg_r <= (baud_reload_reg_r & ~wmask) | (writedata[15:0] & wmask);
      end else if (address == SSP_OFS_MODE) begin
        if (byteenable[0]) begin
          peripheral_function_field_r <= writedata[2:0];
        end
      end else if (address == SSP_OFS_PDIR) begin
        port_direction_reg_r <= (port_direction_reg_r & ~wmask) | (writedata[15:0] & wmask);
      end else if (address == SSP_OFS_PDATA) begin
        port_data_r <= (port_data_r & ~wmask) | (writedata[15:0] & wmask);
      end else if (address == SSP_OFS_CSEN) begin
        if (byteenable[0]) begin
          cs_enable_n_r <= writedata[3:0];
        end
      end
    end
  end

  // ===========================================================================
  // Holding registers and flags
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_holding_reg_r <= 16'h0000;
    end else if (wr_en && address == SSP_OFS_TXH) begin
      tx_holding_reg_r <= (tx_holding_reg_r & ~wmask) | (writedata[15:0] & wmask);
    end
  end

  // A new word written in the cycle the old one is taken stays pending.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_full_r <= 1'b0;
    end else if (wr_en && address == SSP_OFS_TXH) begin
      tx_full_r <= 1'b1;
    end else if (start_load) begin
      tx_full_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_full_r <= 1'b0;
    end else if (final_edge) begin
      rx_full_r <= 1'b1;
    end else if (rd_en && address == SSP_OFS_RXH) begin
      rx_full_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_holding_reg_r <= 16'h0000;
    end else if (final_edge) begin
      rx_holding_reg_r <= rx_word;
    end
  end

  // ===========================================================================
  // Pin synchronisers and the baud divider
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= 16'h0000;
      pin_s2_r <= 16'h0000;
      clk_prev_r <= 1'b0;
    end else begin
      pin_s1_r <= gpp_in;
      pin_s2_r <= pin_s1_r;
      clk_prev_r <= pin_s2_r[SSP_P_CLK];
    end
  end

  // The divider runs whenever the engine is out of idle, slave transfers included, so each
  // transfer starts with a full half-bit period.
  assign tick = (baud_cnt_r == 16'h0000);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      baud_cnt_r <= 16'h0000;
    end else if (state_r == SSP_IDLE || tick) begin
      baud_cnt_r <= baud_reload_reg_r;
    end else begin
      baud_cnt_r <= 16'(baud_cnt_r - 16'h0001);
    end
  end

  // ===========================================================================
  // Shift engine
  assign clk_edge = pin_s2_r[SSP_P_CLK] ^ clk_prev_r;
  assign edge_ev = (state_r == SSP_SHIFT) && (role_master_select ? tick : clk_edge);
  // Even edge numbers are leading edges.
  assign is_sample = (edge_cnt_r[0] == clock_phase_select);
  assign in_bit = role_master_select ? pin_s2_r[SSP_P_MI] : pin_s2_r[SSP_P_MO];
  assign final_edge = edge_ev && (edge_cnt_r == last_edge);
  assign start_load = serial_enable_bit && tx_full_r &&
                      ((state_r == SSP_IDLE) || final_edge);

  // The one register both shifts out and collects input, so counts always match.
  function automatic logic [15:0] ssp_shift(input logic [15:0] sr, input logic b, input logic msb,
                                            input logic [4:0] n);
    logic [15:0] r;
    r = sr;
    if (msb) begin
      r = {sr[14:0], b};
    end else begin
      r = sr >> 1;
      r[4'(n - 5'h01)] = b;
    end
    return r;
  endfunction : ssp_shift

  function automatic logic ssp_first(input logic [15:0] sr, input logic msb, input logic [4:0] n);
    return msb ? sr[4'(n - 5'h01)] : sr[0];
  endfunction : ssp_first

  assign shifted = ssp_shift(shreg_r, sample_r, msb_first_select, nbits);
  assign rx_word = ssp_shift(shreg_r, is_sample ? in_bit : sample_r, msb_first_select, nbits);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= SSP_IDLE;
    end else if (!serial_enable_bit) begin
      state_r <= SSP_IDLE;
    end else begin
      case (state_r)
        SSP_IDLE: begin
          if (start_load) begin
            state_r <= role_master_select ? SSP_LEAD : SSP_SHIFT;
          end
        end
        SSP_LEAD: begin
          if (tick) begin
            state_r <= SSP_SHIFT;
          end
        end
        SSP_SHIFT: begin
          if (final_edge) begin
            if (start_load) begin
              state_r <= role_master_select ? SSP_LEAD : SSP_SHIFT;
            end else begin
              state_r <= role_master_select ? SSP_TRAIL : SSP_IDLE;
            end
          end
        end
        SSP_TRAIL: begin
          if (tick) begin
            state_r <= SSP_IDLE;
          end
        end
        default: begin
          state_r <= SSP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shreg_r <= 16'h0000;
      edge_cnt_r <= 5'h00;
      sample_r <= 1'b0;
    end else if (start_load) begin
      shreg_r <= tx_holding_reg_r;
      edge_cnt_r <= 5'h00;
    end else if (edge_ev) begin
      edge_cnt_r <= 5'(edge_cnt_r + 5'h01);
      if (is_sample) begin
        sample_r <= in_bit;
      end else if (edge_cnt_r != 5'h00) begin
        shreg_r <= shifted;
      end
    end
  end

  // Data-out is never forced back to idle, so it keeps the last bit sent.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_bit_r <= 1'b1;
    end else if (start_load && !role_master_select) begin
      out_bit_r <= ssp_first(tx_holding_reg_r, msb_first_select, nbits);
    end else if (state_r == SSP_LEAD && tick) begin
      out_bit_r <= ssp_first(shreg_r, msb_first_select, nbits);
    end else if (edge_ev && !is_sample && edge_cnt_r != 5'h00 && !final_edge) begin
      out_bit_r <= ssp_first(shifted, msb_first_select, nbits);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_r <= 1'b0;
    end else if (state_r == SSP_SHIFT && role_master_select) begin
      if (tick) begin
        sclk_r <= ~sclk_r;
      end
    end else begin
      sclk_r <= clock_idle_level;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cs_active_r <= 1'b0;
    end else if (!serial_enable_bit || !role_master_select) begin
      cs_active_r <= 1'b0;
    end else if (start_load) begin
      cs_active_r <= 1'b1;
    end else if (state_r == SSP_TRAIL && tick) begin
      cs_active_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      transfer_busy_flag_r <= 1'b0;
      tx_request_irq <= 1'b0;
      rx_complete_irq <= 1'b0;
    end else begin
      tx_request_irq <= start_load;
      rx_complete_irq <= final_edge;
      if (start_load) begin
        transfer_busy_flag_r <= 1'b1;
      end else if (final_edge || !serial_enable_bit) begin
        transfer_busy_flag_r <= 1'b0;
      end
    end
  end

  // ===========================================================================
  // Port pins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gpp_out <= 16'h0000;
    end else begin
      gpp_out <= port_data_r;
      if (peripheral_function_field_r == SSP_MODE_SERIAL) begin
        gpp_out[SSP_P_MO] <= role_master_select ? out_bit_r : port_data_r[SSP_P_MO];
        gpp_out[SSP_P_MI] <= role_master_select ? port_data_r[SSP_P_MI] : out_bit_r;
        gpp_out[SSP_P_CLK] <= serial_enable_bit ? sclk_r : port_data_r[SSP_P_CLK];
        for (int i = 0; i < 4; i++) begin
          gpp_out[SSP_P_CS + i] <= ~(cs_active_r & ~cs_enable_n_r[i]);
        end
      end
    end
  end

  assign gpp_oe = port_direction_reg_r;
endmodule : ssp_top

// *** test/ssp_top_assertions.sv ***
`timescale 1ns/10ps
module ssp_top_assertions
  import ssp_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic [15:0] gpp_in,
  input wire logic [15:0] gpp_out,
  input wire logic [15:0] gpp_oe,
  input wire logic tx_request_irq,
  input wire logic rx_complete_irq
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Register bus handshake.
  sequence s_req_wait;
    (read || write) && waitrequest;
  endsequence
  sequence s_req_ack;
    (read || write) && !waitrequest;
  endsequence
  sequence s_no_rx;
    (!rx_complete_irq) [*3];
  endsequence
  a_wait_first: assert property ($rose(read || write) |-> s_req_wait)
    else $error("access did not start with a wait cycle");
  a_wait_one: assert property (s_req_wait |=> s_req_ack)
    else $error("access took more than one wait cycle");
  a_rd_upper: assert property (s_req_ack and read |-> readdata[31:16] == 16'h0)
    else $error("upper read data not zero");
  a_rd_unmapped: assert property (s_req_ack and read && address > SSP_OFS_CSEN |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  // ==========================================
  // Port and serial engine.
  a_oe_follow: assert property (
    write && !waitrequest && address == SSP_OFS_PDIR && byteenable[1:0] == 2'b11
    |=> gpp_oe == $past(writedata[15:0]))
    else $error("pin direction does not follow write");
  a_tx_pulse: assert property (tx_request_irq |=> !tx_request_irq)
    else $error("transmit request longer than one cycle");
  a_rx_pulse: assert property (rx_complete_irq |=> !rx_complete_irq)
    else $error("receive event longer than one cycle");
  a_tx_first: assert property (tx_request_irq |=> s_no_rx)
    else $error("receive event too soon after load");
  a_cs_lead: assert property ($fell(gpp_out[SSP_P_CS]) |=> $stable(gpp_out[SSP_P_CLK]))
    else $error("clock moved together with chip select");
endmodule : ssp_top_assertions

bind ssp_top ssp_top_assertions ssp_top_assertions_i (.mclk(mclk), .rst_n(rst_n), .address(address),
  .read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .gpp_in(gpp_in), .gpp_out(gpp_out), .gpp_oe(gpp_oe),
  .tx_request_irq(tx_request_irq), .rx_complete_irq(rx_complete_irq));

// *** test/ssp_spi_partner.sv ***
`timescale 1ns/10ps
module ssp_spi_partner (
  input wire logic mclk,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic cs_n,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic msb,
  input wire logic [4:0] width,
  input wire logic [15:0] tx_word,
  output logic miso,
  output logic [15:0] rx_word
);
  // Slave only, so the design stays the single master on the lines.
  logic sp, fresh, tgl, lead, trail;
  logic [15:0] sr, t;
  int oi, ni;
  initial begin
    sp = 1'b0;
    tgl = 1'b0;
    rx_word = 16'h0;
  end
  assign lead = !cs_n && sp == cpol && sclk != cpol;
  assign trail = !cs_n && sp != cpol && sclk == cpol;
  // A deselected slave floats its line, so show a changing level, never a held bit.
  assign miso = cs_n ? tgl : tx_word[msb ? width - 5'd1 - 5'(oi) : 5'(oi)];
  always @(posedge mclk) begin
    sp <= sclk;
    tgl <= !tgl;
    if (cs_n) begin
      fresh <= 1'b1;
      oi <= 0;
      ni <= 0;
    end else begin
      if (cpha ? lead : trail) begin
        fresh <= 1'b0;
        if (!(cpha && fresh)) oi <= (oi + 1 == width) ? 0 : oi + 1;
      end
      if (cpha ? trail : lead) begin
        t = msb ? {(ni == 0) ? 15'h0 : sr[14:0], mosi} : (((ni == 0) ? 16'h0 : sr) | (16'(mosi) << ni));
        sr <= t;
        ni <= (ni + 1 == width) ? 0 : ni + 1;
        if (ni + 1 == width) rx_word <= t;
      end
    end
  end
endmodule : ssp_spi_partner

// *** test/testbench.sv ***
`timescale 1ns/10ps
module testbench;
  import ssp_pkg::*;
  logic mclk, rst_n, read, write, waitrequest, tx_request_irq, rx_complete_irq, miso, pcpol, pcpha, pmsb;
  logic [5:0] address;
  logic [31:0] writedata, readdata;
  logic [3:0] byteenable;
  logic [15:0] gpp_in, gpp_out, gpp_oe, pins, ptx, prx, q, w1, w2, mask, cfg, pdat;
  logic [4:0] pw;
  int err_count, num_checks, n_tx, n_rx, seed, i, base;
  logic [15:0] exp_q[$];
  assign gpp_in = {pins[15:2], miso, pins[0]};
  ssp_top ssp_top_i (.mclk(mclk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .gpp_in(gpp_in), .gpp_out(gpp_out), .gpp_oe(gpp_oe), .tx_request_irq(tx_request_irq),
    .rx_complete_irq(rx_complete_irq));
  ssp_spi_partner ssp_spi_partner_i (.mclk(mclk), .sclk(gpp_out[SSP_P_CLK]), .mosi(gpp_out[SSP_P_MO]),
    .cs_n(gpp_out[SSP_P_CS]), .cpol(pcpol), .cpha(pcpha), .msb(pmsb), .width(pw), .tx_word(ptx),
    .miso(miso), .rx_word(prx));
  // ==========================================
  // Checking and closing.
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  // ==========================================
  // Bus master and waits.
  // Waitrequest and read data are taken at the rising edge, before that edge's updates land.
  task automatic bus(input logic wr, input logic [5:0] a, input logic [15:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    address <= a;
    writedata <= {16'h0, d};
    read <= !wr;
    write <= wr;
    @(posedge mclk);
    while (waitrequest !== 1'b0 && k < 20) begin
      @(posedge mclk);
      k++;
    end
    if (k == 20) begin
      check("bus wait", 16'h1, 16'h0);
      final_report();
    end
    q = readdata[15:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic wait_n(input logic tx, input int target);
    int k;
    k = 0;
    while ((tx ? n_tx : n_rx) < target && k < 5000) begin
      @(negedge mclk);
      k++;
    end
    if (k == 5000) begin
      check("event wait", 16'h1, 16'h0);
      final_report();
    end
  endtask : wait_n
  always @(negedge mclk) begin
    if (tx_request_irq === 1'b1) n_tx++;
    if (rx_complete_irq === 1'b1) n_rx++;
  end
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ==========================================
  // Main sequence.
  initial begin
    seed = 32'h75d4;
    {rst_n, read, write, pcpol, pcpha, pmsb} = 6'h0;
    address = 6'h0;
    writedata = 32'h0;
    byteenable = 4'hf;
    pins = 16'h0;
    ptx = 16'h0;
    pw = 5'd2;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    bus(1'b0, SSP_OFS_CTRL, 16'h0);
    check("ctrl reset", q, SSP_CTRL_RST);
    bus(1'b0, SSP_OFS_BAUD, 16'h0);
    check("baud reset", q, SSP_BAUD_RST);
    bus(1'b0, SSP_OFS_CSEN, 16'h0);
    check("csen reset", q, {12'h0, SSP_CSEN_RST});
    bus(1'b1, 6'h24, 16'h1234);
    bus(1'b0, 6'h24, 16'h0);
    check("unmapped", q, 16'h0);
    bus(1'b1, SSP_OFS_BAUD, 16'hffff);
    bus(1'b0, SSP_OFS_BAUD, 16'h0);
    check("baud", q, 16'hffff);
    $display("test registers done");
    pins <= 16'($random(seed));
    pdat = {8'($random(seed)), 8'hff};
    bus(1'b1, SSP_OFS_PDATA, pdat);
    bus(1'b1, SSP_OFS_MODE, 16'(SSP_MODE_SERIAL));
    bus(1'b1, SSP_OFS_PDIR, 16'hff7d);
    bus(1'b1, SSP_OFS_CSEN, 16'h000e);
    bus(1'b1, SSP_OFS_BAUD, 16'h0004);
    bus(1'b0, SSP_OFS_PIN, 16'h0);
    check("upper pins in", q[15:8], pins[15:8]);
    for (i = 0; i < 6; i++) begin
      pw = (i == 0) ? 5'd2 : (i == 1) ? 5'd16 : 5'(2 + {$random(seed)} % 15);
      pcpha = i[0];
      pcpol = i[1];
      pmsb = i[2] ^ i[0];
      mask = 16'((17'h1 << pw) - 17'h1);
      ptx = 16'($random(seed));
      w1 = 16'($random(seed));
      w2 = 16'($random(seed));
      exp_q.push_back(ptx & mask);
      exp_q.push_back(ptx & mask);
      // The busy bit is written as zero only: software leaves it to the engine.
      cfg = {2'b01, 7'h0, pcpol, pcpha, pmsb, 4'(pw - 5'd1)};
      bus(1'b1, SSP_OFS_CTRL, cfg);
      bus(1'b0, SSP_OFS_CTRL, 16'h0);
      check("config view", q, cfg);
      base = n_tx;
      bus(1'b1, SSP_OFS_TXH, w1);
      repeat (20) @(posedge mclk);
      check("load while off", 16'(n_tx - base), 16'h0);
      bus(1'b1, SSP_OFS_CTRL, cfg | 16'h8000);
      wait_n(1'b1, base + 1);
      bus(1'b1, SSP_OFS_TXH, w2);
      wait_n(1'b0, base + 1);
      bus(1'b0, SSP_OFS_CTRL, 16'h0);
      check("busy held", 16'(q[SSP_B_BUSY]), 16'h1);
      bus(1'b0, SSP_OFS_RXH, 16'h0);
      check("rx word 1", q & mask, exp_q.pop_front());
      wait_n(1'b0, base + 2);
      bus(1'b0, SSP_OFS_CTRL, 16'h0);
      check("status", q & 16'hc700, 16'hc400);
      bus(1'b0, SSP_OFS_RXH, 16'h0);
      check("rx word 2", q & mask, exp_q.pop_front());
      check("partner rx", prx, w2 & mask);
      check("tx events", 16'(n_tx - base), 16'h2);
      check("upper pins out", gpp_out[15:8], pdat[15:8]);
      bus(1'b1, SSP_OFS_CTRL, 16'h0);
      $display("test config %0d width %0d done", i, pw);
    end
    // Slave role: the bench plays master on the clock and data-in pins, 8 bits LSB first.
    w1 = 16'($random(seed));
    w2 = 16'($random(seed));
    pins[2] <= 1'b0;
    bus(1'b1, SSP_OFS_CTRL, 16'h0007);
    bus(1'b1, SSP_OFS_PDIR, 16'hff7a);
    bus(1'b1, SSP_OFS_TXH, w1);
    base = n_rx;
    bus(1'b1, SSP_OFS_CTRL, 16'h8007);
    repeat (4) @(posedge mclk);
    for (i = 0; i < 8; i++) begin
      pins[0] <= w2[i];
      repeat (4) @(posedge mclk);
      check("slave out", 16'(gpp_out[SSP_P_MI]), 16'(w1[i]));
      pins[2] <= 1'b1;
      repeat (4) @(posedge mclk);
      pins[2] <= 1'b0;
      repeat (4) @(posedge mclk);
    end
    wait_n(1'b0, base + 1);
    bus(1'b0, SSP_OFS_RXH, 16'h0);
    check("slave rx", q & 16'h00ff, w2 & 16'h00ff);
    $display("test slave done");
    final_report();
  end
endmodule : testbench
